/* inc/nco_consts.svh */
`ifndef NCO_CONSTS_SVH
`define NCO_CONSTS_SVH
// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define NCO_ACC_W        20
`define NCO_BYTE_W       8
`define NCO_UPPER_W      4
// ----------------------------------------------------------------
// clock source select codes
// ----------------------------------------------------------------
`define NCO_CKS_SYS      3'h0
`define NCO_CKS_HFOSC    3'h1
`define NCO_CKS_LC1      3'h2
`define NCO_CKS_LC4      3'h5
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NCO_ACC_RST      20'h00000
`define NCO_INC_RST      20'h00000
`define NCO_WIDTH_RST    8'h00
// ----------------------------------------------------------------
// increment buffer load delay, in selected clock edges after a write
// ----------------------------------------------------------------
`define NCO_LOAD_EDGES   2'h2
`endif

/* inc/nco_pkg.sv */
package nco_pkg;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [19:0] nco_word_t;   // accumulator and increment word
    typedef enum logic [2:0] {
        NCO_LD_IDLE = 3'b001,          // no load pending
        NCO_LD_WAIT = 3'b010,          // low byte written, counting edges
        NCO_LD_DONE = 3'b100           // buffer loaded this edge
    } nco_load_e;
endpackage : nco_pkg

/* inc/nco_edge_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// selected-clock edge info handed from source selector to core
// ----------------------------------------------------------------
interface nco_edge_if;
    logic tick;    // one-cycle pulse per rising edge of selected source
    logic hf_req;  // request oscillator stay awake in sleep
    modport src (output tick, output hf_req);
    modport dst (input tick, input hf_req);
endinterface : nco_edge_if
`default_nettype wire

/* rtl/nco_clk_sel.sv */
`timescale 1ns/100ps
`default_nettype none
`include "nco_consts.svh"
// ----------------------------------------------------------------
// clock source selector: synchronise, pick, detect rising edge
// ----------------------------------------------------------------
module nco_clk_sel
    import nco_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_enable,     // module enable
    input  wire logic [2:0] i_cks,        // clock source select
    input  wire logic       i_hfosc,      // oscillator as slow square wave
    input  wire logic [3:0] i_lc,         // logic cell outputs
    nco_edge_if.src         edge_o
);
    logic [4:0] meta_r;   // first stage, read only by sync_r
    logic [4:0] sync_r;   // second stage
    logic       sel_r;    // selected level, previous cycle
    logic       sel_nxt;  // selected level now
    logic       tick_r;   // edge pulse

    // two-flop synchronisers for every asynchronous source
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= 5'h00;
            sync_r <= 5'h00;
        end else begin
            meta_r <= {i_lc, i_hfosc};
            sync_r <= meta_r;
        end
    end

    // source mux; system clock gives an edge every second cycle
    always_comb begin
        sel_nxt = 1'b0;
        if (i_cks == `NCO_CKS_SYS) begin
            sel_nxt = ~sel_r;
        end else if (i_cks == `NCO_CKS_HFOSC) begin
            sel_nxt = sync_r[0];
        end else if (i_cks >= `NCO_CKS_LC1 && i_cks <= `NCO_CKS_LC4) begin
            sel_nxt = sync_r[3'(i_cks - `NCO_CKS_LC1) + 3'h1];
        end else begin
            sel_nxt = 1'b0;  // reserved codes give no edges
        end
    end

    // edge detect on the stable stage only
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sel_r  <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            sel_r  <= sel_nxt;
            tick_r <= sel_nxt & ~sel_r;
        end
    end

    assign edge_o.tick   = tick_r;
    assign edge_o.hf_req = i_enable && (i_cks == `NCO_CKS_HFOSC);
endmodule : nco_clk_sel
`default_nettype wire

/* rtl/nco_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "nco_consts.svh"
// Operation
// - 20-bit accumulator as three byte registers
// - each selected edge adds buffered increment
// - adder carry is raw overflow event
// - six selectable accumulator clock sources
// - source code decode, 110/111 reserved
// - increment stored as three byte registers
// - enabled: buffer loads second edge after
// - disabled: buffer loads right after write
// - increment buffer hidden from software
// - fixed duty: output toggles per overflow
// - mode bit picks fixed or pulse
// - pulse mode: active from edge after overflow
// - pulse width is two^field input periods
// - polarity bit inverts final output
// - polarity change raises interrupt when enabled
// - overflow sets interrupt flag
// - request needs all four enables set
// - reset clears every module register but o_pin_oe_n, which it sets high, and ld_st_r, which it loads with NCO_LD_IDLE
// - keeps running in sleep on source
// - oscillator held awake when selected, enabled
// - output to peripherals and optional pin
// - enable bit and output readback status
// - accumulator bytes readable and writable
module nco_top
    import nco_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // control bits
    input  wire logic       i_module_enable,
    input  wire logic       i_pulse_frequency_mode_select,
    input  wire logic       i_output_invert,
    input  wire logic [2:0] i_pulse_width_select,
    input  wire logic [2:0] i_clock_source_select,
    input  wire logic       i_pin_route_enable,
    // clock sources
    input  wire logic       i_high_freq_internal_osc,
    input  wire logic [3:0] i_logic_cell_output,
    input  wire logic       i_sleep,
    // byte write strobes and data
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr_increment_low_byte,
    input  wire logic       i_wr_increment_high_byte,
    input  wire logic       i_wr_increment_upper_byte,
    input  wire logic       i_wr_accumulator_low_byte,
    input  wire logic       i_wr_accumulator_high_byte,
    input  wire logic       i_wr_accumulator_upper_byte,
    // interrupt control
    input  wire logic       i_overflow_irq_enable,
    input  wire logic       i_peripheral_irq_enable,
    input  wire logic       i_global_irq_enable,
    input  wire logic       i_clr_overflow_irq_flag,
    // readback
    output logic [7:0]      o_increment_low_byte,
    output logic [7:0]      o_increment_high_byte,
    output logic [7:0]      o_increment_upper_byte,
    output logic [7:0]      o_accumulator_low_byte,
    output logic [7:0]      o_accumulator_high_byte,
    output logic [7:0]      o_accumulator_upper_byte,
    output logic            o_output_readback,
    output logic            o_overflow_irq_flag,
    output logic            o_irq,
    // synthesized signal
    output logic            o_nco_out,
    output logic            o_pin_out,
    output logic            o_pin_oe_n,
    output logic            o_hfosc_keep_awake
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    nco_edge_if edge_bus ();             // edge pulse from selector
    nco_word_t  acc_r;                   // accumulator
    nco_word_t  inc_r;                   // software-visible increment
    nco_word_t  incbuf_r;                // hidden double buffer
    logic [20:0] sum_nxt;                // full adder incl. carry
    logic       carry_nxt;               // raw overflow event
    logic       tick;                    // selected clock rising edge
    nco_load_e  ld_st_r;                 // buffer load sequencer
    logic [1:0] ld_cnt_r;                // edges seen since low write
    logic       tgl_r;                   // toggle flop
    logic       pls_r;                   // stretched pulse
    logic [7:0] width_cnt_r;             // pulse periods left
    logic       raw_out;                 // mode-selected, pre-polarity
    logic       final_nxt;               // after polarity
    logic       out_r;                   // registered final output
    logic       flag_r;                  // overflow flag
    logic       pol_r;                   // polarity last cycle
    logic       pol_irq;                 // polarity change event
    logic       inc_wr;                  // any increment write

    // ----------------------------------------------------------------
    // source selection and edge generation
    // ----------------------------------------------------------------
    nco_clk_sel u_clk_sel (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_enable  (i_module_enable),
        .i_cks     (i_clock_source_select),
        .i_hfosc   (i_high_freq_internal_osc),
        .i_lc      (i_logic_cell_output),
        .edge_o    (edge_bus.src)
    );

    // sleep does not gate the tick: the block follows its own source
    assign tick = edge_bus.tick & i_module_enable;

    // ----------------------------------------------------------------
    // adder
    // ----------------------------------------------------------------
    // width of sum keeps the carry apart from the wrapped remainder
    assign sum_nxt   = {1'b0, acc_r} + {1'b0, incbuf_r};
    assign carry_nxt = tick & sum_nxt[20];

    // ----------------------------------------------------------------
    // accumulator
    // ----------------------------------------------------------------
    // software write beats an add in the same cycle; undefined anyway
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            acc_r <= `NCO_ACC_RST;
        end else if (i_wr_accumulator_low_byte) begin
            acc_r[7:0] <= i_wdata;
        end else if (i_wr_accumulator_high_byte) begin
            acc_r[15:8] <= i_wdata;
        end else if (i_wr_accumulator_upper_byte) begin
            acc_r[19:16] <= i_wdata[3:0];
        end else if (tick) begin
            acc_r <= sum_nxt[19:0];
        end
    end

    // ----------------------------------------------------------------
    // increment registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            inc_r <= `NCO_INC_RST;
        end else begin
            if (i_wr_increment_low_byte) begin
                inc_r[7:0] <= i_wdata;
            end
            if (i_wr_increment_high_byte) begin
                inc_r[15:8] <= i_wdata;
            end
            if (i_wr_increment_upper_byte) begin
                inc_r[19:16] <= i_wdata[3:0];
            end
        end
    end

    assign inc_wr = i_wr_increment_low_byte | i_wr_increment_high_byte
                  | i_wr_increment_upper_byte;

    // ----------------------------------------------------------------
    // buffer load sequencer
    // ----------------------------------------------------------------
    // relies on upper and high being written first when enabled
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ld_st_r  <= NCO_LD_IDLE;
            ld_cnt_r <= 2'h0;
        end else if (!i_module_enable) begin
            ld_st_r  <= NCO_LD_IDLE;  // disabled loads are immediate
            ld_cnt_r <= 2'h0;
        end else begin
            case (ld_st_r)
                NCO_LD_IDLE: begin
                    if (i_wr_increment_low_byte) begin
                        ld_st_r  <= NCO_LD_WAIT;
                        ld_cnt_r <= 2'h0;
                    end
                end
                NCO_LD_WAIT: begin
                    if (i_wr_increment_low_byte) begin
                        ld_cnt_r <= 2'h0;  // new write restarts the count
                    end else if (tick) begin
                        if (ld_cnt_r + 2'h1 == `NCO_LOAD_EDGES) begin
                            ld_st_r <= NCO_LD_DONE;
                        end
                        ld_cnt_r <= ld_cnt_r + 2'h1;
                    end
                end
                NCO_LD_DONE: begin
                    ld_st_r  <= i_wr_increment_low_byte ? NCO_LD_WAIT : NCO_LD_IDLE;
                    ld_cnt_r <= 2'h0;
                end
                default: begin
                    ld_st_r  <= NCO_LD_IDLE;
                    ld_cnt_r <= 2'h0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // hidden increment buffer, no software path in or out
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            incbuf_r <= `NCO_INC_RST;
        end else if (!i_module_enable) begin
            if (inc_wr) begin
                incbuf_r <= inc_r;  // catches up the cycle after
            end else begin
                incbuf_r <= inc_r;  // keep in step while stopped
            end
        end else if (ld_st_r == NCO_LD_WAIT && tick && !i_wr_increment_low_byte
                     && ld_cnt_r + 2'h1 == `NCO_LOAD_EDGES) begin
            incbuf_r <= inc_r;  // all three bytes together
        end
    end

    // ----------------------------------------------------------------
    // fixed duty toggle
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            tgl_r <= 1'b0;
        end else if (!i_module_enable) begin
            tgl_r <= 1'b0;
        end else if (carry_nxt) begin
            tgl_r <= ~tgl_r;
        end
    end

    // ----------------------------------------------------------------
    // pulse stretcher
    // ----------------------------------------------------------------
    // goes active at the edge that overflows, i.e. the next sys edge
    // after it; width counts selected-clock periods
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pls_r       <= 1'b0;
            width_cnt_r <= `NCO_WIDTH_RST;
        end else if (!i_module_enable) begin
            pls_r       <= 1'b0;
            width_cnt_r <= `NCO_WIDTH_RST;
        end else if (carry_nxt) begin
            pls_r       <= 1'b1;
            width_cnt_r <= 8'(8'h01 << i_pulse_width_select);
        end else if (tick && pls_r) begin
            if (width_cnt_r == 8'h01) begin
                pls_r <= 1'b0;  // width expired
            end
            width_cnt_r <= width_cnt_r - 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // output stages
    // ----------------------------------------------------------------
    assign raw_out   = i_pulse_frequency_mode_select ? pls_r : tgl_r;
    assign final_nxt = raw_out ^ i_output_invert;
    assign pol_irq   = (pol_r != i_output_invert) && i_overflow_irq_enable;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            out_r      <= 1'b0;
            pol_r      <= 1'b0;
            o_pin_out  <= 1'b0;
            o_pin_oe_n <= 1'b1;
        end else begin
            out_r      <= final_nxt;
            pol_r      <= i_output_invert;
            o_pin_out  <= final_nxt;
            o_pin_oe_n <= ~i_pin_route_enable;  // optional pin
        end
    end

    // ----------------------------------------------------------------
    // overflow flag; set wins over a clear in the same cycle
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            flag_r <= 1'b0;
        end else if (carry_nxt || pol_irq) begin
            flag_r <= 1'b1;
        end else if (i_clr_overflow_irq_flag) begin
            flag_r <= 1'b0;  // only software clears
        end
    end

    // ----------------------------------------------------------------
    // registered status and readback
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_irq                    <= 1'b0;
            o_overflow_irq_flag      <= 1'b0;
            o_output_readback        <= 1'b0;
            o_nco_out                <= 1'b0;
            o_hfosc_keep_awake       <= 1'b0;
            o_increment_low_byte     <= 8'h00;
            o_increment_high_byte    <= 8'h00;
            o_increment_upper_byte   <= 8'h00;
            o_accumulator_low_byte   <= 8'h00;
            o_accumulator_high_byte  <= 8'h00;
            o_accumulator_upper_byte <= 8'h00;
        end else begin
            o_irq <= flag_r && i_module_enable && i_overflow_irq_enable
                     && i_peripheral_irq_enable && i_global_irq_enable;
            o_overflow_irq_flag      <= flag_r;
            o_output_readback        <= out_r;
            o_nco_out                <= out_r;
            o_hfosc_keep_awake       <= edge_bus.hf_req && i_sleep;
            o_increment_low_byte     <= inc_r[7:0];
            o_increment_high_byte    <= inc_r[15:8];
            o_increment_upper_byte   <= {4'h0, inc_r[19:16]};
            o_accumulator_low_byte   <= acc_r[7:0];
            o_accumulator_high_byte  <= acc_r[15:8];
            o_accumulator_upper_byte <= {4'h0, acc_r[19:16]};
        end
    end
endmodule : nco_top
`default_nettype wire

/* verification/nco_top_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "nco_consts.svh"
// ----------------------------------------------------------------
// port checker for the oscillator top
// ----------------------------------------------------------------
module nco_top_monitor (
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    input wire logic       i_module_enable,
    input wire logic       i_pulse_frequency_mode_select,
    input wire logic       i_output_invert,
    input wire logic [2:0] i_clock_source_select,
    input wire logic       i_sleep,
    input wire logic       i_pin_route_enable,
    input wire logic       i_overflow_irq_enable,
    input wire logic       i_peripheral_irq_enable,
    input wire logic       i_global_irq_enable,
    input wire logic       i_clr_overflow_irq_flag,
    input wire logic [7:0] o_increment_upper_byte,
    input wire logic [7:0] o_accumulator_upper_byte,
    input wire logic       o_output_readback,
    input wire logic       o_overflow_irq_flag,
    input wire logic       o_irq,
    input wire logic       o_nco_out,
    input wire logic       o_pin_oe_n,
    input wire logic       o_hfosc_keep_awake
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic       inv_r;     // last sampled polarity bit
    logic [2:0] steady_r;  // edges with fixed duty and polarity unchanged
    // polarity history
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) inv_r <= 1'b0;
        else inv_r <= i_output_invert;
    end
    // quiet-control history: only then must an output change come from an overflow
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) steady_r <= 3'h0;
        else steady_r <= {steady_r[1:0],
            ~i_pulse_frequency_mode_select & (i_output_invert == inv_r)};
    end
    sequence all_enables_s;
        $past(i_module_enable & i_overflow_irq_enable & i_peripheral_irq_enable & i_global_irq_enable);
    endsequence
    sequence flag_seen_s;
        $past(o_overflow_irq_flag);
    endsequence
    readback_match_a: assert property (o_output_readback == o_nco_out)
        else $error("readback differs from output");
    upper_nibble_a: assert property ((o_increment_upper_byte[7:4] == 4'h0)
        && (o_accumulator_upper_byte[7:4] == 4'h0))
        else $error("upper byte unused bits set");
    irq_gate_a: assert property (o_irq |-> all_enables_s)
        else $error("request without all enables");
    irq_flag_a: assert property (o_irq |-> o_overflow_irq_flag)
        else $error("request without flag");
    flag_sticky_a: assert property (o_overflow_irq_flag && !$past(i_clr_overflow_irq_flag)
        |=> o_overflow_irq_flag)
        else $error("flag cleared without software");
    pin_route_a: assert property (!o_pin_oe_n |-> $past(i_pin_route_enable))
        else $error("pin driven while not routed");
    keep_awake_a: assert property (o_hfosc_keep_awake |-> $past(i_module_enable
        && (i_clock_source_select == `NCO_CKS_HFOSC) && i_sleep))
        else $error("oscillator held without cause");
    duty_toggle_a: assert property ($changed(o_nco_out) && (steady_r == 3'h7) |-> flag_seen_s)
        else $error("fixed duty toggle without overflow");
endmodule : nco_top_monitor
bind nco_top nco_top_monitor u_mon (.i_clk_sys, .i_rst, .i_module_enable, .i_pulse_frequency_mode_select,
    .i_output_invert, .i_clock_source_select, .i_sleep, .i_pin_route_enable, .i_overflow_irq_enable,
    .i_peripheral_irq_enable, .i_global_irq_enable, .i_clr_overflow_irq_flag, .o_increment_upper_byte,
    .o_accumulator_upper_byte, .o_output_readback, .o_overflow_irq_flag, .o_irq, .o_nco_out,
    .o_pin_oe_n, .o_hfosc_keep_awake);
`default_nettype wire

/* verification/nco_peri_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// consuming peripheral: counts every transition it is handed
// ----------------------------------------------------------------
module nco_peri_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_nco_out,
    output logic      [15:0] o_edges
);
    logic last_r;  // previous output level
    // count changes, counter wraps silently on long runs
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            last_r  <= 1'b0;
            o_edges <= 16'h0000;
        end else begin
            last_r <= i_nco_out;
            if (last_r != i_nco_out) o_edges <= o_edges + 16'h0001;
        end
    end
endmodule : nco_peri_model
`default_nettype wire

/* verification/nco_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module nco_top_tb;
    import nco_pkg::*;
    typedef struct packed { logic [2:0] sel; logic [7:0] d; logic [7:0] e; } nco_row_s;
    // sel below 6 is a byte write, 6 picks clock source d and expects activity e
    nco_row_s rows [17] = '{'{3, 8'h11, 8'h11}, '{4, 8'h22, 8'h22}, '{5, 8'hF7, 8'h07},
        '{0, 8'h5A, 8'h5A}, '{1, 8'hC3, 8'hC3}, '{2, 8'hFF, 8'h0F}, '{2, 8'h08, 8'h08},
        '{1, 8'h00, 8'h00}, '{0, 8'h00, 8'h00}, '{6, 8'h00, 8'h01}, '{6, 8'h01, 8'h01},
        '{6, 8'h02, 8'h01}, '{6, 8'h03, 8'h01}, '{6, 8'h04, 8'h01}, '{6, 8'h05, 8'h01},
        '{6, 8'h06, 8'h00}, '{6, 8'h07, 8'h00}};
    logic        clk = 1'b0, rst = 1'b1, en = 1'b0, pfm = 1'b0, inv = 1'b0;
    logic        route = 1'b0, slp = 1'b0, clr = 1'b0, p;
    logic [2:0]  pws = 3'h0, cks = 3'h0, ie = 3'h0;  // ie is {global, peripheral, overflow}
    logic [7:0]  wd = 8'h00;
    logic [5:0]  ws = 6'h00, sq = 6'h00;  // write strobes, square-wave source counter
    logic [7:0]  rb [6];
    logic        o_nco, rdb, flg, irq, pout, oe_n, awake;
    logic [15:0] edges;
    int          errors = 0, compares = 0, cyc = 0, i, n;
    nco_row_s    r;
    always #25 clk = ~clk;
    // free-running sources at fixed ratios to the system clock
    always @(posedge clk) sq <= sq + 6'h01;
    nco_top dut (.i_clk_sys(clk), .i_rst(rst), .i_module_enable(en),
        .i_pulse_frequency_mode_select(pfm), .i_output_invert(inv), .i_pulse_width_select(pws),
        .i_clock_source_select(cks), .i_pin_route_enable(route), .i_high_freq_internal_osc(sq[1]),
        .i_logic_cell_output(sq[5:2]), .i_sleep(slp), .i_wdata(wd), .i_wr_increment_low_byte(ws[0]),
        .i_wr_increment_high_byte(ws[1]), .i_wr_increment_upper_byte(ws[2]),
        .i_wr_accumulator_low_byte(ws[3]), .i_wr_accumulator_high_byte(ws[4]),
        .i_wr_accumulator_upper_byte(ws[5]), .i_overflow_irq_enable(ie[0]),
        .i_peripheral_irq_enable(ie[1]), .i_global_irq_enable(ie[2]), .i_clr_overflow_irq_flag(clr),
        .o_increment_low_byte(rb[0]), .o_increment_high_byte(rb[1]), .o_increment_upper_byte(rb[2]),
        .o_accumulator_low_byte(rb[3]), .o_accumulator_high_byte(rb[4]),
        .o_accumulator_upper_byte(rb[5]), .o_output_readback(rdb), .o_overflow_irq_flag(flg),
        .o_irq(irq), .o_nco_out(o_nco), .o_pin_out(pout), .o_pin_oe_n(oe_n),
        .o_hfosc_keep_awake(awake));
    nco_peri_model u_peri (.i_clk_sys(clk), .i_rst(rst), .i_nco_out(o_nco), .o_edges(edges));
    task automatic print_verdict;
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] x);
        compares++;
        if (s !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    // one-cycle strobe, data held with it
    task automatic wr(input int sel, input logic [7:0] d);
        @(posedge clk);
        wd <= d;
        ws <= 6'h01 << sel;
        @(posedge clk);
        ws <= 6'h00;
    endtask : wr
    // upper and high go before low so the buffer takes a whole word
    task automatic inc(input logic [7:0] u);
        wr(2, u);
        wr(1, 8'h00);
        wr(0, 8'h00);
    endtask : inc
    // length in cycles of the next full run at level lvl
    task automatic meas(input logic lvl, output int c);
        int k;
        k = 0;
        c = 0;
        while (o_nco !== ~lvl && k < 600) begin @(posedge clk); k++; end
        while (o_nco !== lvl && k < 600) begin @(posedge clk); k++; end
        while (o_nco === lvl && c < 600) begin @(posedge clk); c++; end
    endtask : meas
    // hang guard: the planned run is well below this
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin errors++; print_verdict(); end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        for (i = 0; i < 6; i++) chk("reset byte", rb[i], 0);
        chk("reset flags", {o_nco, flg, irq, oe_n}, 1);
        @(posedge clk);
        slp <= 1'b1;
        for (i = 0; i < 17; i++) begin
            r = rows[i];
            if (r.sel < 6) begin
                wr(r.sel, r.d);
                repeat (3) @(posedge clk);
                #1 chk("readback", rb[r.sel], r.e);
            end else begin
                @(posedge clk);
                cks <= r.d[2:0];
                en <= 1'b1;
                repeat (10) @(posedge clk);
                n = edges;
                repeat (600) @(posedge clk);
                chk("source active", edges != n, r.e);
                if (r.d == 8'h01) chk("keep awake", awake, 1);
            end
        end
        @(posedge clk);
        {en, cks, slp, route, ie} <= {1'b0, 3'h0, 1'b0, 1'b1, 3'h7};
        inc(8'h04);
        @(posedge clk);
        en <= 1'b1;
        meas(1'b1, n);
        chk("duty period", n, 8);
        chk("pin enable", {oe_n, pout}, 0);
        chk("flag set", flg, 1);
        chk("irq on", irq, 1);
        inc(8'h08);
        meas(1'b1, n);
        meas(1'b1, n);
        chk("reloaded period", n, 4);
        for (i = 0; i < 4; i++) begin
            {en, ie} <= 4'hF ^ (4'h1 << i);
            repeat (20) @(posedge clk);
            chk("irq masked", irq, 0);
            chk("flag kept", flg, 1);
        end
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (3) @(posedge clk);
        chk("flag cleared", flg, 0);
        p = o_nco;
        inv <= 1'b1;
        repeat (5) @(posedge clk);
        chk("inverted", o_nco, !p);
        chk("flag on invert", flg, 1);
        {inv, pfm, en} <= 3'b011;
        inc(8'h01);
        for (i = 0; i < 4; i++) begin
            pws <= i[2:0];
            meas(1'b1, n);
            meas(1'b1, n);
            chk("pulse width", n, 2 << i);
        end
        print_verdict();
    end
endmodule : nco_top_tb
`default_nettype wire
